// ===== two_wire_bus_framing_asserts.sv
// Concurrent checks on the two-wire link between both ends
`timescale 1ns/1ns
`default_nettype none
module two_wire_bus_framing_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link lines and drives
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_oe,
  // Target status
  input wire logic bus_idle,
  input wire logic in_frame
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic       start_w;
  logic       stop_w;
  logic [3:0] cnt_r;
  logic [7:0] byte_r;
  logic       rd_r;
  logic       nack_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  assign start_w = scl && scl_q_r && sda_q_r && !sda;
  assign stop_w  = scl && scl_q_r && !sda_q_r && sda;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end
  // Pulse index in the byte, F until the fall that closes a start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_r <= 4'hF;
    else if (start_w || stop_w) cnt_r <= 4'hF;
    else if (scl_q_r && !scl) cnt_r <= (cnt_r >= 4'h8) ? 4'h0 : cnt_r + 4'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) byte_r <= 8'h00;
    else if (start_w) byte_r <= 8'h00;
    else if (scl_q_r && !scl && cnt_r == 4'h8) byte_r <= byte_r + 8'h01;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rd_r <= 1'b0;
    else if (start_w) rd_r <= 1'b0;
    else if (scl && cnt_r == 4'h7 && byte_r == 8'h00) rd_r <= sda;
  end
  // Read ended by the controller, its own stop or start follows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) nack_r <= 1'b0;
    else if (start_w || stop_w) nack_r <= 1'b0;
    else if (scl && rd_r && byte_r != 8'h00 && cnt_r == 4'h8 && sda) nack_r <= 1'b1;
  end

  sequence s_nack_fall;
    nack_r && $fell(scl);
  endsequence
  sequence s_released;
    ##4 (!dev_sda_oe) [*4];
  endsequence

  a_idle_flag: assert property ((scl && sda) [*5] |-> bus_idle)
    else $error("bus idle flag missing");
  a_busy_flag: assert property ((!scl || !sda) [*5] |-> !bus_idle)
    else $error("bus idle flag while a line is low");
  a_start_frame: assert property (start_w |-> ##[1:5] in_frame)
    else $error("start not recognised");
  a_stop_frame: assert property (stop_w |-> ##[1:5] !in_frame)
    else $error("stop not recognised");
  a_dev_steady: assert property (scl && scl_q_r |-> $stable(dev_sda_oe))
    else $error("target drive changed while clock high");
  a_hdr_ack: assert property (scl && cnt_r == 4'h8 && byte_r == 8'h00
    |-> dev_sda_oe && !sda)
    else $error("header byte not acknowledged");
  a_wr_quiet: assert property (scl && !rd_r && cnt_r < 4'h8 |-> !dev_sda_oe)
    else $error("target drove a data bit of a write");
  a_rd_quiet: assert property (scl && rd_r && !nack_r && byte_r != 8'h00
    && cnt_r < 4'h8 |-> !ctl_sda_oe)
    else $error("controller drove a data bit of a read");
  a_nack_release: assert property (s_nack_fall |-> s_released)
    else $error("target kept the data line after not-acknowledge");
  c_nack: cover property (s_nack_fall);
endmodule
`default_nettype wire

// ===== two_wire_bus_framing_tb.sv
// Self-checking bench joining controller and target over the two-wire link
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
module two_wire_bus_framing_tb;
  import two_wire_pkg::*;
  localparam int LIM = 40000;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_rd = 1'b0;
  logic        cmd_rs = 1'b0;
  logic [7:0]  cmd_len = 8'h00;
  logic        tx_valid = 1'b1;
  logic        wr_ready = 1'b0;
  logic [7:0]  tx_data, rx_data, b;
  logic [15:0] wr_data, rd_word;
  logic        cmd_ready, tx_take, rx_valid, done, nacked;
  logic        wr_valid, wr_msb_only, rd_take, bus_idle, in_frame;
  int          n_fail = 0;
  int          tests_run = 0;
  int          tx_i = 0;
  int          rd_i = 0;
  logic [7:0]  txb [0:127];
  logic [15:0] rdw [0:3];
  logic [16:0] wq [$];
  logic [7:0]  rq [$];

  always #25 clk = !clk;
  assign tx_data = txb[tx_i[6:0]];
  assign rd_word = rdw[rd_i[1:0]];
  // Byte source, word source and output collectors
  always @(posedge clk) begin
    if (tx_take) tx_i <= tx_i + 1;
    if (rd_take) rd_i <= rd_i + 1;
    if (rx_valid) rq.push_back(rx_data);
    if (wr_valid && wr_ready) wq.push_back({wr_msb_only, wr_data});
  end

  two_wire_if bus_if ();
  two_wire_controller #(.QTR(4)) two_wire_controller_inst (.clk(clk), .nrst(nrst),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rd(cmd_rd),
    .cmd_len(cmd_len), .cmd_rs(cmd_rs), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid), .done(done), .nacked(nacked));
  two_wire_target #(.DEPTH(FIFO_DEPTH)) two_wire_target_inst (.clk(clk), .nrst(nrst),
    .bus(bus_if), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .wr_msb_only(wr_msb_only), .rd_word(rd_word), .rd_take(rd_take),
    .bus_idle(bus_idle), .in_frame(in_frame));
  two_wire_bus_framing_asserts two_wire_bus_framing_asserts_inst (.clk(clk), .nrst(nrst),
    .scl(bus_if.scl), .sda(bus_if.sda), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .bus_idle(bus_idle), .in_frame(in_frame));

  task results;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // One command: wait for ready, hand it over, wait for done
  task xfer(input logic rd, input logic [7:0] len, input logic rs);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < LIM) begin tick(1); k++; end
    cmd_rd = rd;
    cmd_len = len;
    cmd_rs = rs;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && k < LIM) begin tick(1); k++; end
    if (k >= LIM) begin
      n_fail++;
      $display("[ERR] done expected 1 seen timeout");
      results();
    end
  endtask

  task s_idle;
    tick(6);
    `CHK("bus_idle", 1'b1, bus_idle)
    `CHK("sda", 1'b1, bus_if.sda)
    `CHK("in_frame", 1'b0, in_frame)
  endtask

  task s_write;
    wr_ready = 1'b1;
    wq.delete();
    xfer(1'b0, 8'h00, 1'b0);
    `CHK("nacked hdr", 1'b0, nacked)
    b = tx_i[7:0];
    xfer(1'b0, 8'h03, 1'b0);
    tick(8);
    `CHK("words", 2, wq.size())
    `CHK("pair", {1'b0, b, b + 8'h01}, wq[0])
    `CHK("lone", {1'b1, b + 8'h02, 8'h00}, wq[1])
    `CHK("nacked", 1'b0, nacked)
    `CHK("in_frame", 1'b0, in_frame)
  endtask

  task s_rs_read;
    int r;
    wq.delete();
    rq.delete();
    b = tx_i[7:0];
    r = rd_i;
    xfer(1'b0, 8'h01, 1'b1);
    tick(8);
    `CHK("in_frame rs", 1'b1, in_frame)
    xfer(1'b1, 8'h03, 1'b0);
    tick(8);
    `CHK("lone rs", {1'b1, b, 8'h00}, wq[0])
    `CHK("rx count", 3, rq.size())
    `CHK("rx0", rdw[r[1:0]][15:8], rq[0])
    `CHK("rx1", rdw[r[1:0]][7:0], rq[1])
    `CHK("rx2", rdw[r[1:0] + 2'd1][15:8], rq[2])
    `CHK("words taken", 2, rd_i - r)
    `CHK("dev drive", 1'b0, bus_if.dev_sda_oe)
    `CHK("idle", 1'b1, bus_idle)
  endtask

  task s_full;
    logic [7:0] e;
    int k;
    wr_ready = 1'b0;
    wq.delete();
    b = tx_i[7:0];
    xfer(1'b0, 8'd66, 1'b0);
    `CHK("refused", 1'b1, nacked)
    wr_ready = 1'b1;
    k = 0;
    while (wr_valid !== 1'b0 && k < 100) begin tick(1); k++; end
    if (k >= 100) begin
      n_fail++;
      $display("[ERR] wr_valid expected 0 seen timeout");
      results();
    end else begin
      tick(2);
      `CHK("drained", 32, wq.size())
      for (int i = 0; i < 32; i++) begin
        e = b + 8'(2 * i);
        `CHK("fifo word", {1'b0, e, e + 8'h01}, wq[i])
      end
    end
  endtask

  initial begin
    for (int i = 0; i < 128; i++) txb[i] = 8'(i);
    rdw[0] = 16'h1234;
    rdw[1] = 16'hABCD;
    rdw[2] = 16'h5AF0;
    rdw[3] = 16'h0FC3;
    tick(4);
    nrst = 1'b1;
    s_idle();
    s_write();
    s_rs_read();
    s_full();
    results();
  end
endmodule
`default_nettype wire

// ===== two_wire_controller.sv
// Controller end of the two-wire link, making the serial clock
`timescale 1ns/1ns
`default_nettype none
module two_wire_controller #(
  parameter int QTR = two_wire_pkg::SCL_QTR_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Link
  two_wire_if.controller  bus,
  // Command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_rd,
  input  wire logic [7:0] cmd_len,
  input  wire logic       cmd_rs,
  // Write bytes
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_take,
  // Read bytes and status
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            done,
  output logic            nacked
);
  import two_wire_pkg::*;

  ctl_state_t  state_r;
  logic [15:0] div_r;
  logic        tick, run, accept, sda_in, last;
  logic        sda_s1_r, sda_s2_r;
  logic [1:0]  q_r;
  logic [2:0]  bit_r;
  logic [7:0]  sh_r, cnt_r;
  logic        rd_r, rs_r, hdr_r, scl_oe_r, sda_oe_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  assign sda_in = sda_s2_r;
  assign run    = state_r == C_START || state_r == C_BITS || state_r == C_ACK ||
                  state_r == C_STOP;
  assign tick   = run && div_r == 16'(QTR - 1);
  assign accept = (state_r == C_IDLE || state_r == C_PAUSE) && cmd_valid && cmd_ready;
  assign last   = nacked || (hdr_r ? cnt_r == 8'h00 : cnt_r == 8'h01); // R4

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 16'h0000;
    end else if (!run || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= C_IDLE;
      q_r       <= 2'h0;
      bit_r     <= 3'h0;
      sh_r      <= 8'h00;
      cnt_r     <= 8'h00;
      rd_r      <= 1'b0;
      rs_r      <= 1'b0;
      hdr_r     <= 1'b0;
      scl_oe_r  <= RST_OE;
      sda_oe_r  <= RST_OE;
      cmd_ready <= 1'b1;
      tx_take   <= 1'b0;
      rx_data   <= 8'h00;
      rx_valid  <= 1'b0;
      done      <= 1'b0;
      nacked    <= 1'b0;
    end else begin
      tx_take  <= 1'b0;
      rx_valid <= 1'b0;
      done     <= 1'b0;
      if (tick) begin
        q_r <= q_r + 2'h1;
      end
      case (state_r)
        C_IDLE, C_PAUSE: begin
          q_r <= 2'h0;
          if (accept) begin
            rd_r      <= cmd_rd;
            cnt_r     <= cmd_len;
            rs_r      <= cmd_rs;
            sh_r      <= {HDR_TAG, cmd_rd};
            hdr_r     <= 1'b1;
            nacked    <= 1'b0;
            cmd_ready <= 1'b0;
            state_r   <= C_START;
          end
        end
        C_START: begin
          if (tick) begin
            case (q_r)
              2'h0: sda_oe_r <= 1'b0; // R10
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b1; // R2
              default: begin
                scl_oe_r <= 1'b1;
                bit_r    <= 3'h7;
                state_r  <= C_BITS;
              end
            endcase
          end
        end
        C_BITS: begin
          if (tick) begin
            case (q_r)
              2'h0: sda_oe_r <= (hdr_r || !rd_r) ? !sh_r[7] : 1'b0; // R10
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sh_r <= {sh_r[6:0], sda_in};
              default: begin
                scl_oe_r <= 1'b1;
                if (bit_r == 3'h0) begin
                  state_r <= C_ACK; // R9
                end else begin
                  bit_r <= bit_r - 3'h1;
                end
              end
            endcase
          end
        end
        C_ACK: begin
          if (tick) begin
            case (q_r)
              2'h0: sda_oe_r <= (!hdr_r && rd_r) ? cnt_r != 8'h01 : 1'b0; // R6 R7 R8
              2'h1: scl_oe_r <= 1'b0;
              2'h2: begin
                if (!hdr_r && rd_r) begin
                  rx_data  <= sh_r;
                  rx_valid <= 1'b1;
                end else begin
                  nacked <= sda_in;
                end
              end
              default: begin
                scl_oe_r <= 1'b1;
                state_r  <= C_NEXT;
              end
            endcase
          end
        end
        C_NEXT: begin
          q_r <= 2'h0;
          if (last && rs_r) begin
            cmd_ready <= 1'b1; // R3
            done      <= 1'b1;
            state_r   <= C_PAUSE;
          end else if (last) begin
            state_r <= C_STOP;
          end else if (rd_r || tx_valid) begin
            if (!hdr_r) begin
              cnt_r <= cnt_r - 8'h01;
            end
            if (!rd_r) begin
              sh_r    <= tx_data;
              tx_take <= 1'b1;
            end
            hdr_r   <= 1'b0;
            bit_r   <= 3'h7;
            state_r <= C_BITS;
          end
        end
        C_STOP: begin
          if (tick) begin
            case (q_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_oe_r <= 1'b0;
              2'h2: sda_oe_r <= 1'b0; // R3
              default: begin
                cmd_ready <= 1'b1;
                done      <= 1'b1;
                state_r   <= C_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_r <= C_IDLE;
        end
      endcase
    end
  end

  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe     = scl_oe_r;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = sda_oe_r;
endmodule
`default_nettype wire

// ===== two_wire_if.sv
// Open-drain two-wire link joining the controller end and the target end
`timescale 1ns/1ns
`default_nettype none
interface two_wire_if;
  logic scl_o;
  logic scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-and with pull-up: a line is low while any enabled driver pulls it low
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport controller (input scl, input sda, output scl_o, output scl_oe,
                      output ctl_sda_o, output ctl_sda_oe);
endinterface
`default_nettype wire

// ===== two_wire_pkg.sv
// Shared constants and state types for both ends of the two-wire link
package two_wire_pkg;
  localparam int BYTE_BITS  = 8;
  localparam int WORD_BITS  = 16;
  localparam int FIFO_DEPTH = 32;
  // Clock of both ends and quarter period of the generated serial clock
  localparam int CLK_NS      = 50;
  localparam int SCL_QTR_NS  = 625;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
  // Last bit counted in a byte, the ninth pulse is the acknowledge
  localparam logic [3:0] BIT_LAST = 4'h8;
  // Arbitrary neutral tag sent in the upper seven bits of the header byte
  localparam logic [6:0] HDR_TAG = 7'h00;
  localparam logic       RST_OE  = 1'b0;

  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_RX     = 3'b001,
    D_ACK    = 3'b010,
    D_TX     = 3'b011,
    D_TXACK  = 3'b100,
    D_TXNEXT = 3'b101,
    D_WAIT   = 3'b110
  } dev_state_t;

  typedef enum logic [2:0] {
    C_IDLE  = 3'b000,
    C_START = 3'b001,
    C_BITS  = 3'b010,
    C_ACK   = 3'b011,
    C_NEXT  = 3'b100,
    C_STOP  = 3'b101,
    C_PAUSE = 3'b110
  } ctl_state_t;
endpackage

// ===== two_wire_target.sv
// Target end of the two-wire link with its write-word FIFO
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_r;
  logic [AW:0]  rptr_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wptr_r[AW] == rptr_r[AW]) || (wptr_r[AW-1:0] != rptr_r[AW-1:0]);
  assign out_valid = wptr_r != rptr_r;
  assign out_data  = mem[rptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rptr_r <= rptr_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// Summary of operation
// R1: Both lines high means the bus is idle
// R2: Data falling with clock high is start
// R3: Data rising with clock high is stop
// R4: Any number of bytes per transfer accepted while the word FIFO has room
// R5: Lone high byte before start/stop updates alone
// R6: Receiver acknowledges every byte while addressed, except a write byte arriving with the word FIFO full; the controller nacks the last read byte
// R7: Acknowledge holds data low through clock high
// R8: Controller not-acknowledge ends read, line released
// R9: Eight data pulses then one acknowledge pulse
// R10: Data changes only while clock is low
// R11: Words travel high byte first, then low
// R12: Sample on rise, drive after fall
module two_wire_target #(
  parameter int DEPTH = two_wire_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              nrst,
  // Link
  two_wire_if.device                             bus,
  // Received words
  output logic                                   wr_valid,
  input  wire logic                              wr_ready,
  output logic [two_wire_pkg::WORD_BITS-1:0]     wr_data,
  output logic                                   wr_msb_only,
  // Word to send on reads
  input  wire logic [two_wire_pkg::WORD_BITS-1:0] rd_word,
  output logic                                   rd_take,
  // Status
  output logic                                   bus_idle,
  output logic                                   in_frame
);
  import two_wire_pkg::*;
  dev_state_t     state_r;
  logic           scl_s1_r, scl_s2_r, scl_q_r;
  logic           sda_s1_r, sda_s2_r, sda_q_r;
  logic           rise, fall, start_c, stop_c;
  logic [3:0]     bit_r;
  logic [7:0]     sh_r, tsh_r, lsb_r, msb_r;
  logic           first_r, rd_r, pend_r, sel_r, oe_r;
  logic           push_v, fifo_rdy;
  logic [WORD_BITS:0] push_d;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_q_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_q_r  <= 1'b1;
    end else begin
      scl_s1_r <= bus.scl;
      scl_s2_r <= scl_s1_r;
      scl_q_r  <= scl_s2_r;
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
      sda_q_r  <= sda_s2_r;
    end
  end

  assign rise    = scl_s2_r && !scl_q_r; // R12
  assign fall    = !scl_s2_r && scl_q_r; // R12
  assign start_c = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r; // R2 R10
  assign stop_c  = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r; // R3 R10

  // Pending high byte goes out alone when the transfer ends early
  always_comb begin
    push_v = 1'b0;
    push_d = '0;
    if ((start_c || stop_c) && pend_r) begin
      push_v = 1'b1; // R5
      push_d = {1'b1, msb_r, 8'h00}; // R5
    end else if (state_r == D_RX && fall && bit_r == BIT_LAST && !first_r && pend_r &&
                 fifo_rdy) begin
      push_v = 1'b1;
      push_d = {1'b0, msb_r, sh_r}; // R11
    end
  end

  word_fifo #(.W(WORD_BITS + 1), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push_v),
    .in_ready  (fifo_rdy),
    .in_data   (push_d),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_msb_only, wr_data})
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= D_IDLE;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      tsh_r   <= 8'h00;
      lsb_r   <= 8'h00;
      msb_r   <= 8'h00;
      first_r <= 1'b0;
      rd_r    <= 1'b0;
      pend_r  <= 1'b0;
      sel_r   <= 1'b0;
      oe_r    <= RST_OE;
      rd_take <= 1'b0;
    end else begin
      rd_take <= 1'b0;
      if (start_c) begin
        state_r <= D_RX; // R2
        bit_r   <= 4'h0;
        first_r <= 1'b1;
        oe_r    <= 1'b0;
        pend_r  <= 1'b0;
      end else if (stop_c) begin
        state_r <= D_IDLE; // R3
        oe_r    <= 1'b0;
        pend_r  <= 1'b0;
      end else begin
        case (state_r)
          D_RX: begin
            if (rise) begin
              sh_r  <= {sh_r[6:0], sda_s2_r}; // R12
              bit_r <= bit_r + 4'h1; // R9
            end else if (fall && bit_r == BIT_LAST) begin
              bit_r <= 4'h0;
              if (first_r) begin
                rd_r    <= sh_r[0];
                oe_r    <= 1'b1; // R6 R7
                state_r <= D_ACK;
              end else if (fifo_rdy) begin
                oe_r    <= 1'b1; // R6 R7
                state_r <= D_ACK;
                if (pend_r) begin
                  pend_r <= 1'b0;
                end else begin
                  msb_r  <= sh_r; // R11
                  pend_r <= 1'b1;
                end
              end else begin
                state_r <= D_WAIT;
              end
            end
          end
          D_ACK: begin
            if (fall) begin
              if (rd_r) begin
                tsh_r   <= rd_word[15:8]; // R11
                lsb_r   <= rd_word[7:0];
                rd_take <= 1'b1;
                sel_r   <= 1'b1;
                oe_r    <= !rd_word[15]; // R10 R12
                state_r <= D_TX;
              end else begin
                oe_r    <= 1'b0;
                first_r <= 1'b0;
                state_r <= D_RX; // R4
              end
            end
          end
          D_TX: begin
            if (rise) begin
              bit_r <= bit_r + 4'h1;
            end else if (fall) begin
              if (bit_r == BIT_LAST) begin
                oe_r    <= 1'b0; // R9
                bit_r   <= 4'h0;
                state_r <= D_TXACK;
              end else begin
                tsh_r <= {tsh_r[6:0], 1'b0};
                oe_r  <= !tsh_r[6]; // R10 R12
              end
            end
          end
          D_TXACK: begin
            if (rise) begin
              state_r <= sda_s2_r ? D_WAIT : D_TXNEXT; // R8
            end
          end
          D_TXNEXT: begin
            if (fall) begin
              if (sel_r) begin
                tsh_r <= lsb_r; // R11
                sel_r <= 1'b0;
                oe_r  <= !lsb_r[7];
              end else begin
                tsh_r   <= rd_word[15:8];
                lsb_r   <= rd_word[7:0];
                rd_take <= 1'b1;
                sel_r   <= 1'b1;
                oe_r    <= !rd_word[15];
              end
              state_r <= D_TX; // R4
            end
          end
          D_IDLE, D_WAIT: begin
            oe_r <= 1'b0; // R8
          end
          default: begin
            state_r <= D_IDLE;
            oe_r    <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_idle <= 1'b0;
      in_frame <= 1'b0;
    end else begin
      bus_idle <= scl_s2_r && sda_s2_r; // R1
      in_frame <= state_r != D_IDLE;
    end
  end
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_r;
endmodule
`default_nettype wire
